// ===== flash_params.svh
// constants for the flash block erase and protection logic
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

`define FL_DW         32
`define FL_AW         13
`define FL_WORDS      8192
`define FL_BLK_AW     8
`define FL_BLOCKS     32
`define FL_BLK_MSB    12
`define FL_BLK_LSB    8
`define FL_UNITS      16
`define FL_UNIT_LSB   9
`define FL_UNIT_W     4
`define FL_ERASED     32'hFFFF_FFFF
`define FL_BLK_LAST   8'hFF

`endif

// ===== flash_pkg.sv
// types shared by the flash access and protection logic
`include "flash_params.svh"

package flash_pkg;

    typedef enum logic [2:0] {
        OP_FETCH,
        OP_DREAD,
        OP_DBG,
        OP_PROG,
        OP_ERASE
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_ERASE
    } fsm_t;

    typedef struct packed {
        logic                valid;
        op_t                 op;
        logic [`FL_AW-1:0]   addr;
        logic [`FL_DW-1:0]   wdata;
    } req_t;

    typedef struct packed {
        logic                rvalid;
        logic                done;
        logic                err;
        logic [`FL_DW-1:0]   rdata;
    } rsp_t;

    typedef struct packed {
        fsm_t                st;
        logic [`FL_BLK_AW-1:0] cnt;
        logic [`FL_AW-`FL_BLK_AW-1:0] blk;
        logic                done;
        logic                err;
    } state_t;

endpackage

// ===== flash_array.sv
// single-port flash word array with registered read data
`include "flash_params.svh"

module flash_array (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // access port
    input  wire logic              en,
    input  wire logic              we,
    input  wire logic [`FL_AW-1:0] addr,
    input  wire logic [`FL_DW-1:0] wdata,
    output logic      [`FL_DW-1:0] rdata
);

    logic [`FL_DW-1:0] mem [`FL_WORDS];

    // array itself carries no reset; only the read register does
    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (en && !we) begin
            rdata <= mem[addr];
        end
    end

endmodule

// ===== flash_block_erase_protect.sv
// access, block erase and per-unit protection logic for the on-chip flash
`include "flash_params.svh"

module flash_block_erase_protect (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // protection settings, one bit per 2 KB unit
    input  wire logic [`FL_UNITS-1:0] unit_ro,
    input  wire logic [`FL_UNITS-1:0] unit_xo,
    // request from fetch, data path or debugger
    input  wire flash_pkg::req_t      req,
    output logic                      req_ready,
    // answer
    output flash_pkg::rsp_t           rsp
);

    flash_pkg::state_t r_r;
    flash_pkg::state_t r_nxt;

    logic              mem_en;
    logic              mem_we;
    logic [`FL_AW-1:0] mem_addr;
    logic [`FL_DW-1:0] mem_wdata;
    logic [`FL_DW-1:0] mem_rdata;

    logic [`FL_UNITS-1:0] wr_locked;
    logic [`FL_UNITS-1:0] rd_locked;
    logic                 acc;
    logic                 refused;

    function automatic logic [`FL_UNIT_W-1:0] unit_of(input logic [`FL_AW-1:0] a);
        unit_of = a[`FL_BLK_MSB:`FL_UNIT_LSB];
    endfunction

    // decides refusal from the addressed unit's bits only
    function automatic logic refuse(input flash_pkg::op_t op,
                                    input logic wr_lock,
                                    input logic rd_lock);
        case (op)
            flash_pkg::OP_FETCH: refuse = 1'b0;
            flash_pkg::OP_DREAD: refuse = rd_lock;
            flash_pkg::OP_DBG:   refuse = rd_lock;
            flash_pkg::OP_PROG:  refuse = wr_lock;
            flash_pkg::OP_ERASE: refuse = wr_lock;
            default:             refuse = 1'b1;
        endcase
    endfunction

    genvar u;
    generate
        for (u = 0; u < `FL_UNITS; u = u + 1) begin : g_unit
            assign wr_locked[u] = unit_ro[u] | unit_xo[u];
            assign rd_locked[u] = unit_xo[u];
        end
    endgenerate

    assign req_ready = (r_r.st == flash_pkg::ST_IDLE);
    assign acc       = req.valid && req_ready;
    assign refused   = refuse(req.op, wr_locked[unit_of(req.addr)],
                              rd_locked[unit_of(req.addr)]);

    always_comb begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        r_nxt.err  = 1'b0;
        mem_en     = 1'b0;
        mem_we     = 1'b0;
        mem_addr   = req.addr;
        mem_wdata  = req.wdata;
        case (r_r.st)
            flash_pkg::ST_IDLE: begin
                if (acc && refused) begin
                    // nothing reaches the array on a refusal
                    r_nxt.err = 1'b1;
                end else if (acc) begin
                    case (req.op)
                        flash_pkg::OP_PROG: begin
                            mem_en     = 1'b1;
                            mem_we     = 1'b1;
                            r_nxt.done = 1'b1;
                        end
                        flash_pkg::OP_ERASE: begin
                            r_nxt.st  = flash_pkg::ST_ERASE;
                            r_nxt.cnt = '0;
                            r_nxt.blk = req.addr[`FL_BLK_MSB:`FL_BLK_LSB];
                        end
                        default: begin
                            mem_en   = 1'b1;
                            r_nxt.st = flash_pkg::ST_READ;
                        end
                    endcase
                end
            end
            flash_pkg::ST_READ: begin
                r_nxt.st = flash_pkg::ST_IDLE;
            end
            flash_pkg::ST_ERASE: begin
                // one word per cycle; the block index is frozen, so no other block moves
                mem_en    = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = {r_r.blk, r_r.cnt};
                mem_wdata = `FL_ERASED;
                r_nxt.cnt = `FL_BLK_AW'(r_r.cnt + 8'h01);
                if (r_r.cnt == `FL_BLK_LAST) begin
                    r_nxt.st   = flash_pkg::ST_IDLE;
                    r_nxt.done = 1'b1;
                end
            end
            default: begin
                r_nxt.st = flash_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    flash_array u_array (
        .clk    (clk),
        .arst_n (arst_n),
        .en     (mem_en),
        .we     (mem_we),
        .addr   (mem_addr),
        .wdata  (mem_wdata),
        .rdata  (mem_rdata)
    );

    assign rsp.rvalid = (r_r.st == flash_pkg::ST_READ);
    assign rsp.done   = r_r.done;
    assign rsp.err    = r_r.err;
    assign rsp.rdata  = mem_rdata;

    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic acc_wr;
    logic acc_rd_data;
    assign acc_wr      = acc && (req.op == flash_pkg::OP_PROG || req.op == flash_pkg::OP_ERASE);
    assign acc_rd_data = acc && (req.op == flash_pkg::OP_DREAD || req.op == flash_pkg::OP_DBG);

    // block fields of the request and of the array address, kept apart for the history checks
    logic [`FL_AW-`FL_BLK_AW-1:0] req_blk;
    logic [`FL_AW-`FL_BLK_AW-1:0] mem_blk;
    assign req_blk = req.addr[`FL_BLK_MSB:`FL_BLK_LSB];
    assign mem_blk = mem_addr[`FL_BLK_MSB:`FL_BLK_LSB];

    sequence s_erase_start;
        acc && req.op == flash_pkg::OP_ERASE && !refused;
    endsequence

    sequence s_erase_walk;
        (r_r.st == flash_pkg::ST_ERASE && r_r.cnt == 8'h00)
        ##255 (r_r.st == flash_pkg::ST_ERASE && r_r.cnt == 8'hFF)
        ##1 (r_r.st == flash_pkg::ST_IDLE && rsp.done);
    endsequence

    chk_erase_length: assert property (
        s_erase_start |=> s_erase_walk)
        else $error("erase did not walk exactly one block");

    // first erase write lands in the requested block, every later one stays there
    chk_erase_block: assert property (
        (r_r.st == flash_pkg::ST_ERASE) |->
            (mem_we && (($past(r_r.st) == flash_pkg::ST_ERASE) ?
                        $stable(mem_blk) : (mem_blk == $past(req_blk)))))
        else $error("erase write left its block");

    chk_erase_ones: assert property (
        (r_r.st == flash_pkg::ST_ERASE) |-> (mem_wdata == `FL_ERASED))
        else $error("erase wrote a zero bit");

    chk_unit_indep: assert property (
        acc_wr && !unit_ro[unit_of(req.addr)] && !unit_xo[unit_of(req.addr)]
            |=> !rsp.err)
        else $error("write refused by another unit setting");

    chk_ro_refuse: assert property (
        acc_wr && unit_ro[unit_of(req.addr)] |-> !mem_we ##1 (rsp.err && !rsp.done))
        else $error("write to read-only unit not refused");

    chk_ro_read: assert property (
        acc && req.op == flash_pkg::OP_DREAD && unit_ro[unit_of(req.addr)] &&
        !unit_xo[unit_of(req.addr)] |=> (rsp.rvalid && !rsp.err))
        else $error("read of read-only unit denied");

    chk_xo_data: assert property (
        acc_rd_data && unit_xo[unit_of(req.addr)] |-> !mem_en ##1 (rsp.err && !rsp.rvalid))
        else $error("data read of execute-only unit served");

    chk_xo_fetch: assert property (
        acc && req.op == flash_pkg::OP_FETCH |=> (rsp.rvalid && !rsp.err))
        else $error("instruction fetch not served");

    chk_err_quiet: assert property (
        rsp.err |-> (!$past(mem_en) && !rsp.rvalid && !rsp.done))
        else $error("refused access reached the array");

    chk_erase_busy: assert property (
        (r_r.st == flash_pkg::ST_ERASE) |-> (!req_ready && !rsp.rvalid))
        else $error("request taken while a block erase runs");

    chk_one_answer: assert property (
        $onehot0({rsp.rvalid, rsp.done, rsp.err}))
        else $error("more than one answer flag at once");

    chk_bad_op: assert property (
        acc && (req.op > flash_pkg::OP_ERASE) |-> !mem_en ##1 (rsp.err && !rsp.done))
        else $error("unknown operation reached the array");

endmodule

// ===== flash_requester.sv
// requester model standing for the fetch path, data path and debugger
module flash_requester (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // command from the bench
    input  wire logic            start,
    input  wire flash_pkg::req_t cmd,
    // flash side
    input  wire logic            ready,
    output flash_pkg::req_t      req
);
    timeunit 1ns;
    timeprecision 1ns;
    // held until taken; released lines show the inverse so a stale value never matches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req <= '0;
        end else if (req.valid && ready) begin
            req <= ~req;
        end else if (start && !req.valid) begin
            req <= cmd;
        end
    end
endmodule

// ===== tb_flash_block_erase_protect.sv
// self-checking bench for the flash access, erase and protection logic
module tb_flash_block_erase_protect;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic           p;
        flash_pkg::op_t op;
        logic [12:0]    a;
        logic [31:0]    d;
        logic [2:0]     f;
    } row_t;
    logic            clk = 1'b0;
    logic            arst_n = 1'b0;
    logic            start = 1'b0;
    logic [15:0]     unit_ro = 16'h0000;
    logic [15:0]     unit_xo = 16'h0000;
    flash_pkg::req_t cmd = '0;
    flash_pkg::req_t req;
    logic            req_ready;
    flash_pkg::rsp_t rsp;
    int              mismatches = 0;
    int              compares = 0;
    int              waited;
    row_t            rows [14];
    always #25 clk = ~clk;
    flash_requester host (.clk(clk), .arst_n(arst_n), .start(start), .cmd(cmd),
                          .ready(req_ready), .req(req));
    flash_block_erase_protect dut (.clk(clk), .arst_n(arst_n), .unit_ro(unit_ro),
                                   .unit_xo(unit_xo), .req(req), .req_ready(req_ready),
                                   .rsp(rsp));
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flags(input logic [2:0] got, input logic [2:0] exp);
        cmp_word({29'h0, got}, {29'h0, exp});
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // unit 1 read-only, unit 2 execute-only while p is set
    task automatic step(input row_t r, input int w);
        @(posedge clk);
        unit_ro <= r.p ? 16'h0002 : 16'h0000;
        unit_xo <= r.p ? 16'h0004 : 16'h0000;
        cmd <= '{valid: 1'b1, op: r.op, addr: r.a, wdata: r.d};
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        // waited counts edges from the taking edge to the one that samples the answer
        for (waited = 1; waited <= 300; waited++) begin
            @(posedge clk);
            #1;
            if ((rsp.rvalid | rsp.done | rsp.err) === 1'b1) break;
        end
        cmp_flags({rsp.rvalid, rsp.done, rsp.err}, r.f);
        if (r.f == 3'h4) cmp_word(rsp.rdata, r.d);
        cmp_word(waited, w);
    endtask
    initial begin
        #250000;
        mismatches++;
        end_sim();
    end
    initial begin
        rows = '{
            '{1'b0, flash_pkg::OP_PROG, 13'h0200, 32'h1111_0001, 3'h2},
            '{1'b0, flash_pkg::OP_PROG, 13'h0400, 32'h2222_0002, 3'h2},
            '{1'b0, flash_pkg::OP_PROG, 13'h0010, 32'h3333_0003, 3'h2},
            '{1'b1, flash_pkg::OP_PROG, 13'h0200, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_ERASE, 13'h0300, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_DREAD, 13'h0200, 32'h1111_0001, 3'h4},
            '{1'b1, flash_pkg::OP_PROG, 13'h0400, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_ERASE, 13'h0400, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_DREAD, 13'h0400, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_DBG, 13'h0400, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_FETCH, 13'h0400, 32'h2222_0002, 3'h4},
            '{1'b1, flash_pkg::OP_DBG, 13'h0010, 32'h3333_0003, 3'h4},
            '{1'b0, flash_pkg::op_t'(3'h5), 13'h0010, 32'h0000_0000, 3'h1},
            '{1'b1, flash_pkg::OP_PROG, 13'h0020, 32'h6666_0006, 3'h2}
        };
        repeat (3) @(posedge clk);
        cmp_flags({req_ready, rsp.rvalid, rsp.err}, 3'h4);
        cmp_word(rsp.rdata, 32'h0000_0000);
        arst_n <= 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            step(rows[i], 1);
            $display("test row %0d done", i);
        end
        step('{1'b0, flash_pkg::OP_PROG, 13'h0100, 32'h4444_0004, 3'h2}, 1);
        step('{1'b0, flash_pkg::OP_PROG, 13'h00FF, 32'h5555_0005, 3'h2}, 1);
        step('{1'b0, flash_pkg::OP_ERASE, 13'h0080, 32'h0000_0000, 3'h2}, 257);
        step('{1'b0, flash_pkg::OP_DREAD, 13'h0010, 32'hFFFF_FFFF, 3'h4}, 1);
        step('{1'b0, flash_pkg::OP_DREAD, 13'h00FF, 32'hFFFF_FFFF, 3'h4}, 1);
        step('{1'b0, flash_pkg::OP_DREAD, 13'h0100, 32'h4444_0004, 3'h4}, 1);
        $display("test block erase done");
        // a reset in the middle of an erase must drop it and leave the port ready
        @(posedge clk);
        cmd   <= '{valid: 1'b1, op: flash_pkg::OP_ERASE, addr: 13'h0100, wdata: 32'h0};
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        cmp_flags({req_ready, rsp.done, rsp.err}, 3'h0);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_flags({req_ready, rsp.done, rsp.err}, 3'h4);
        arst_n <= 1'b1;
        step('{1'b0, flash_pkg::OP_PROG, 13'h0100, 32'h7777_0007, 3'h2}, 1);
        step('{1'b0, flash_pkg::OP_DREAD, 13'h0100, 32'h7777_0007, 3'h4}, 1);
        $display("test reset in erase done");
        end_sim();
    end
endmodule
